// ===== verilog/btc_pkg.sv
// shared constants and types of the branch target cache and prefetch engine
`default_nettype none
package btc_pkg;
  // geometry
  localparam int unsigned SLOT_COUNT      = 63;    // cache slots of four bytes
  localparam int unsigned TAG_W           = 15;    // upper bits of a 17-bit code address
  localparam int unsigned PTR_W           = 6;     // slot index and lock pointer width
  // register byte addresses
  localparam logic [7:0]  ADDR_CTRL       = 8'h80;
  localparam logic [7:0]  ADDR_TUNE       = 8'h84;
  localparam logic [7:0]  ADDR_FSTAT      = 8'h88;
  localparam logic [7:0]  ADDR_LOCK       = 8'h8c;
  // reset values
  localparam logic [7:0]  CTRL_RST        = 8'he6;
  localparam logic [7:0]  TUNE_RST        = 8'h00;
  localparam logic [7:0]  LOCK_RST        = 8'h3e;
  localparam logic [7:0]  FSTAT_RST       = 8'h00;
  // cache_control fields
  localparam int unsigned CTRL_FILL       = 7;     // cache_fill_enable
  localparam int unsigned CTRL_LOOKUP     = 6;     // cache_lookup_enable
  localparam int unsigned CTRL_PREFETCH   = 5;     // prefetch_engine_enable
  localparam int unsigned CTRL_FLUSH      = 4;     // cache_invalidate_all
  localparam int unsigned CTRL_INTERRUPT_RETURN       = 3;     // cache_interrupt_return_targets
  localparam int unsigned CTRL_ISR        = 2;     // cache_service_routine_code
  localparam int unsigned CTRL_TABLE      = 1;     // cache_table_read_data
  // cache_tuning fields
  localparam int unsigned TUNE_ALG        = 3;     // replacement_algorithm_select
  localparam int unsigned TUNE_FIX        = 2;     // table_reads_fixed_slot
  localparam int unsigned TUNE_THR_HI     = 1;     // miss_stall_threshold msb
  localparam int unsigned TUNE_THR_LO     = 0;     // miss_stall_threshold lsb
  // cache_lock_control fields
  localparam int unsigned LOCK_PUSH       = 7;     // lock_push_enable
  localparam int unsigned LOCK_POP        = 6;     // lock_pop_strobe
  // flash_status fields
  localparam int unsigned STAT_BUSY       = 0;     // flash_program_busy
  // timing: flash access rounds up to whole clocks
  localparam int unsigned FLASH_ACCESS_NS = 40;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned FLASH_CYC_I     = (FLASH_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0]  FLASH_CYC       = 3'(FLASH_CYC_I < 1 ? 1 : FLASH_CYC_I);
  localparam logic [7:0]  LFSR_SEED       = 8'h01;
  // fetch request from the core
  typedef struct packed {
    logic [16:0] addr;      // byte address of the code fetch
    logic        table_rd;  // code_table_read data fetch
    logic        interrupt_return_tgt;  // destination of an interrupt_return
    logic        isr_code;  // fetch belongs to a service routine
  } btc_fetch_s;
  // fetch sequencer states
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_FETCH = 2'b01,
    S_WAIT  = 2'b10,
    S_ACK   = 2'b11
  } btc_state_e;
endpackage
`default_nettype wire

// ===== verilog/btc_branch_cache.sv
// branch target cache with one-word prefetch engine and ahb-lite registers
//
// Added by the designer: the AHB-Lite interface to the registers.
`default_nettype none
module btc_branch_cache
  import btc_pkg::*;
#(
  parameter int unsigned SLOTS = SLOT_COUNT
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        fetch_req,
  input  wire btc_fetch_s  fetch_info,
  output logic             fetch_ack,
  output logic [31:0]      fetch_data,
  output logic             fetch_stall,
  output logic             flash_rd_en,
  output logic [14:0]      flash_rd_tag,
  input  wire logic [31:0] flash_rd_data,
  input  wire logic        flash_wr_busy,
  input  wire logic        flash_inval,
  input  wire logic [16:0] flash_inval_addr,
  input  wire logic        flash_inval_page
);

  ////////////////////////////////////////////////////////////////////////////
  // storage and state
  logic [TAG_W-1:0] tag_mem  [SLOTS];   // slot tags
  logic [31:0]      slot_mem [SLOTS];   // slot bytes
  logic [SLOTS-1:0] valid;              // slot valid bits
  logic [TAG_W-1:0] lin_tag;            // linear tag owned by prefetch
  logic [31:0]      lin_data;           // linear slot bytes
  logic             lin_valid;          // linear slot holds data
  btc_state_e       state;              // fetch sequencer
  logic [2:0]       fl_cnt;             // flash read countdown, 0 = idle
  logic             fl_pf;              // flash read belongs to prefetch
  logic [2:0]       stall_cnt;          // stall cycles of current miss
  logic [7:0]       ctrl;               // cache_control
  logic [3:0]       tune;               // cache_tuning
  logic             lock_push;          // lock_push_enable
  logic [PTR_W-1:0] lock_ptr;           // lock_slot_pointer
  logic             stat_busy;          // flash_program_busy
  logic [PTR_W-1:0] rb_idx;             // rebound position
  logic             rb_down;            // rebound sweeping downward
  logic [7:0]       lfsr;               // free running random source
  logic             dp_wr;              // write data phase pending
  logic             dp_rd;              // read data phase pending
  logic [7:0]       dp_addr;            // data phase address

  // invalidation test for one tag: word write or 1 KiB page erase
  function automatic logic inval_hit(input logic [TAG_W-1:0] t);
    if (flash_inval_page) begin
      return t[TAG_W-1:8] == flash_inval_addr[16:10];
    end
    return t == flash_inval_addr[16:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // lookup
  wire  [TAG_W-1:0] req_tag   = fetch_info.addr[16:2];
  wire              lookup_en = ctrl[CTRL_LOOKUP];
  wire              pf_en     = ctrl[CTRL_PREFETCH];
  wire  [SLOTS-1:0] match;
  logic [PTR_W-1:0] hit_idx;

  // parallel compare against every valid tag
  for (genvar g = 0; g < SLOTS; g++) begin : g_cmp
    assign match[g] = valid[g] & (tag_mem[g] == req_tag);
  end

  // lowest matching slot wins; duplicates only arise with lookup off or from a lock push of a table read that hits
  always_comb begin
    hit_idx = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (match[i]) begin
        hit_idx = PTR_W'(i);
      end
    end
  end

  wire pf_busy   = (fl_cnt != 3'h0) & fl_pf;
  wire cache_hit = lookup_en & (|match);
  // linear slot only serves while the prefetch engine runs
  wire lin_hit   = pf_en & lin_valid & (lin_tag == req_tag);
  // a read finishing this very cycle is not waited on: the sequencer
  // would miss its done strobe and hang, so it is refetched instead
  wire pf_match  = pf_en & pf_busy & ~fl_done & (flash_rd_tag == req_tag);
  wire idle_req  = (state == S_IDLE) & fetch_req;
  wire fl_done   = (fl_cnt == 3'h1);
  wire busy_st   = (state == S_FETCH) | (state == S_WAIT);

  ////////////////////////////////////////////////////////////////////////////
  // answer path
  wire        idle_hit     = idle_req & (cache_hit | lin_hit);
  wire        issue_demand = idle_req & ~cache_hit & ~lin_hit & ~pf_match;
  wire        enter_wait   = idle_req & ~cache_hit & ~lin_hit & pf_match;
  wire        answer_now   = idle_hit | (busy_st & fl_done);
  wire        from_flash   = busy_st;
  wire [31:0] ans_data     = from_flash ? flash_rd_data
                           : (cache_hit ? slot_mem[hit_idx] : lin_data);
  wire [TAG_W-1:0] next_tag = TAG_W'(req_tag + 15'h1);
  // after each answer keep the following word on its way
  wire        issue_pf     = answer_now & pf_en & ~issue_demand
                           & ~(lin_valid & (lin_tag == next_tag) & ~fl_done)
                           & ~(pf_busy & ~fl_done & (flash_rd_tag == next_tag));

  ////////////////////////////////////////////////////////////////////////////
  // fill decision
  wire [1:0] thr       = tune[TUNE_THR_HI:TUNE_THR_LO];
  wire       cacheable = (~fetch_info.interrupt_return_tgt | ctrl[CTRL_INTERRUPT_RETURN])
                       & (~fetch_info.isr_code | ctrl[CTRL_ISR])
                       & (~fetch_info.table_rd | ctrl[CTRL_TABLE]);
  wire       push_op   = answer_now & lock_push & fetch_info.table_rd;
  wire       fill_ok   = answer_now & from_flash & ctrl[CTRL_FILL]
                       & cacheable & (stall_cnt > {1'b0, thr})
                       & ~push_op;
  wire       cache_wr  = push_op | fill_ok;
  wire       fixed_fill = fetch_info.table_rd & tune[TUNE_FIX];

  ////////////////////////////////////////////////////////////////////////////
  // replacement selection within the unlocked range
  // pointer at zero means nothing is locked
  wire [PTR_W-1:0] unl_hi  = (lock_ptr == '0) ? PTR_W'(SLOTS - 1) : lock_ptr;
  wire [6:0]       rnd_w   = {1'b0, lfsr[5:0]} % ({1'b0, unl_hi} + 7'h01);
  wire [PTR_W-1:0] rnd_idx = rnd_w[PTR_W-1:0];
  wire [PTR_W-1:0] rb_cur  = (rb_idx > unl_hi) ? unl_hi : rb_idx;
  wire [PTR_W-1:0] repl_idx = tune[TUNE_ALG] ? rnd_idx : rb_cur;
  wire [PTR_W-1:0] wr_idx  = push_op ? lock_ptr
                           : (fixed_fill ? '0 : repl_idx);
  wire             rb_step = fill_ok & ~fixed_fill & ~tune[TUNE_ALG];

  // rebound walk: up to the top of the free range, then back down
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rb_idx  <= '0;
      rb_down <= 1'b0;
    end else if (rb_step) begin
      if (!rb_down && rb_cur >= unl_hi) begin
        rb_down <= 1'b1;
        rb_idx  <= rb_cur - 6'h01;
      end else if (rb_down && rb_cur == '0) begin
        rb_down <= 1'b0;
        rb_idx  <= 6'h01;
      end else begin
        rb_idx  <= rb_down ? rb_cur - 6'h01 : rb_cur + 6'h01;
      end
    end
  end

  // lfsr runs every cycle so the pick depends on fetch timing
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      lfsr <= LFSR_SEED;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus
  wire       ap_take   = hsel & htrans[1] & hready;
  wire       wr_ctrl   = dp_wr & (dp_addr == ADDR_CTRL);
  wire       wr_tune   = dp_wr & (dp_addr == ADDR_TUNE);
  wire       wr_lock   = dp_wr & (dp_addr == ADDR_LOCK);
  wire       flush_now = wr_ctrl & hwdata[CTRL_FLUSH];
  wire       pop_now   = wr_lock & hwdata[LOCK_POP];
  wire [7:0] rd_lock   = {lock_push, 1'b0, lock_ptr};
  wire [7:0] rd_stat   = {7'h00, stat_busy};
  wire [7:0] rd_byte   = (haddr[7:0] == ADDR_CTRL)  ? ctrl
                       : (haddr[7:0] == ADDR_TUNE)  ? {4'h0, tune}
                       : (haddr[7:0] == ADDR_FSTAT) ? rd_stat
                       : (haddr[7:0] == ADDR_LOCK)  ? rd_lock : 8'h00;

  // address phase capture; read data is loaded for the data phase
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dp_wr     <= 1'b0;
      dp_rd     <= 1'b0;
      dp_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_wr     <= ap_take & hwrite;
      dp_rd     <= ap_take & ~hwrite;
      dp_addr   <= haddr[7:0];
      hrdata    <= (ap_take & ~hwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      hreadyout <= 1'b1;       // zero wait states
      hresp     <= 1'b0;       // always okay
    end
  end

  // software registers; flush and pop are strobes, never stored
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl      <= CTRL_RST;
      tune      <= TUNE_RST[3:0];
      lock_push <= LOCK_RST[LOCK_PUSH];
      stat_busy <= FSTAT_RST[STAT_BUSY];
    end else begin
      if (wr_ctrl) begin
        ctrl <= {hwdata[7:5], 1'b0, hwdata[3:1], 1'b0};
      end
      if (wr_tune) begin
        tune <= hwdata[3:0];
      end
      if (wr_lock) begin
        lock_push <= hwdata[LOCK_PUSH];
      end
      stat_busy <= flash_wr_busy;
    end
  end

  // push and pop in one cycle cancel out
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      lock_ptr <= LOCK_RST[PTR_W-1:0];
    end else if (push_op && !pop_now) begin
      lock_ptr <= lock_ptr - 6'h01;
    end else if (pop_now && !push_op) begin
      lock_ptr <= lock_ptr + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fetch sequencer and flash read engine
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state       <= S_IDLE;
      fetch_ack   <= 1'b0;
      fetch_data  <= 32'h0000_0000;
      fetch_stall <= 1'b0;
      stall_cnt   <= 3'h0;
    end else begin
      fetch_ack <= answer_now;
      if (answer_now) begin
        fetch_data <= ans_data;
      end
      case (state)
        S_IDLE: begin
          if (idle_hit) begin
            state <= S_ACK;
          end else if (issue_demand) begin
            state <= S_FETCH;
          end else if (enter_wait) begin
            state <= S_WAIT;
          end
        end
        S_FETCH, S_WAIT: begin
          if (fl_done) begin
            state <= S_ACK;
          end
        end
        S_ACK: begin
          state <= S_IDLE;     // request still up this cycle, skip it
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
      if (issue_demand || enter_wait) begin
        fetch_stall <= 1'b1;
        stall_cnt   <= 3'h1;
      end else if (answer_now) begin
        fetch_stall <= 1'b0;
      end else if (busy_st && stall_cnt != 3'h7) begin
        stall_cnt   <= stall_cnt + 3'h1;
      end
    end
  end

  // a new demand read restarts the flash port, abandoning the prefetch
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      fl_cnt       <= 3'h0;
      fl_pf        <= 1'b0;
      flash_rd_en  <= 1'b0;
      flash_rd_tag <= '0;
    end else begin
      flash_rd_en <= issue_demand | issue_pf;
      if (issue_demand) begin
        fl_cnt       <= FLASH_CYC + 3'h1;
        fl_pf        <= 1'b0;
        flash_rd_tag <= req_tag;
      end else if (issue_pf) begin
        fl_cnt       <= FLASH_CYC + 3'h1;
        fl_pf        <= 1'b1;
        flash_rd_tag <= next_tag;
      end else if (fl_cnt != 3'h0) begin
        fl_cnt <= fl_cnt - 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tag and slot arrays
  // every finished flash word lands in the linear slot; clears win
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      lin_valid <= 1'b0;
      lin_tag   <= '0;
      lin_data  <= 32'h0000_0000;
      valid     <= '0;
    end else begin
      if (fl_done) begin
        lin_valid <= 1'b1;
        lin_tag   <= flash_rd_tag;
        lin_data  <= flash_rd_data;
      end
      if (cache_wr) begin
        valid[wr_idx] <= 1'b1;
      end
      for (int i = 0; i < SLOTS; i++) begin
        if (flash_inval && inval_hit(tag_mem[i])) begin
          valid[i] <= 1'b0;
        end
      end
      if (flash_inval && inval_hit(fl_done ? flash_rd_tag : lin_tag)) begin
        lin_valid <= 1'b0;
      end
      if (flush_now) begin
        valid     <= '0;
        lin_valid <= 1'b0;
      end
    end
  end

  // payload arrays need no reset: valid bits guard them
  always_ff @(posedge sys_clk) begin
    if (cache_wr) begin
      tag_mem[wr_idx]  <= req_tag;
      slot_mem[wr_idx] <= ans_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence seq_miss_start;
    idle_req && !cache_hit && !lin_hit;
  endsequence
  sequence seq_answer;
    fetch_ack && !fetch_stall;
  endsequence

  AST_HIT_NO_STALL: assert property (idle_hit |=> fetch_ack && !fetch_stall)
    else $error("hit did not answer at once");
  AST_MISS_BOUND: assert property (seq_miss_start |=> fetch_stall ##[1:4] seq_answer)
    else $error("miss stall too long");
  AST_PF_WAIT: assert property (enter_wait |=> !flash_rd_en ##1 fetch_ack)
    else $error("prefetch wait restarted flash");
  AST_FLUSH: assert property (flush_now |=> valid == '0 && !lin_valid)
    else $error("flush left valid slots");
  AST_PUSH_DEC: assert property (push_op && !pop_now |=>
    lock_ptr == $past(lock_ptr) - 6'h01)
    else $error("push did not decrement pointer");
  AST_LOCKED_SAFE: assert property (fill_ok && lock_ptr != '0 |-> wr_idx <= lock_ptr)
    else $error("fill hit a locked slot");
  AST_FIXED_SLOT: assert property (fill_ok && fixed_fill |-> wr_idx == '0)
    else $error("fixed table read not in slot zero");
  AST_FILL_GATED: assert property (cache_wr && !push_op |-> ctrl[CTRL_FILL] &&
    stall_cnt > {1'b0, thr})
    else $error("fill while not allowed");
  AST_POP_ZERO: assert property (dp_rd && dp_addr == ADDR_LOCK |-> hrdata[LOCK_POP] == 1'b0)
    else $error("pop bit read as one");
  AST_BUSY: assert property (flash_wr_busy ##2 (dp_rd && dp_addr == ADDR_FSTAT) |->
    hrdata[STAT_BUSY])
    else $error("busy not shown");

endmodule
`default_nettype wire

// ===== tb/btc_flash_model.sv
// flash array model: timed word reads and program cycles
`default_nettype none
module btc_flash_model
  import btc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        flash_rd_en,
  input  wire logic [14:0] flash_rd_tag,
  input  wire logic        prog_go,
  input  wire logic [16:0] prog_addr,
  output logic [31:0]      flash_rd_data,
  output logic             flash_wr_busy,
  output logic             flash_inval,
  output logic [16:0]      flash_inval_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0]  age;   // cycles into a read, 0 when idle
  logic [14:0] word;  // word under read
  logic [2:0]  left;  // program cycles still to run
  // outside the access window the data is inverted, so stale data never matches
  assign flash_rd_data = (age != 3'h0) ? {1'b0, word, 1'b1, ~word} : {1'b1, ~word, 1'b0, word};
  assign flash_wr_busy = (left != 3'h0);
  ////////////////////////////////////////////////////////////////////////////////
  // reads take the access time in whole clocks; a new start aborts the old one
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      age <= 3'h0;
      word <= 15'h0000;
      left <= 3'h0;
      flash_inval <= 1'b0;
      flash_inval_addr <= 17'h00000;
    end else begin
      age <= flash_rd_en ? 3'h1 : (age == FLASH_CYC || age == 3'h0) ? 3'h0 : age + 3'h1;
      if (flash_rd_en) begin
        word <= flash_rd_tag;
      end
      left <= prog_go ? 3'h6 : (left != 3'h0) ? left - 3'h1 : 3'h0;
      flash_inval <= (left == 3'h1);
      flash_inval_addr <= prog_addr;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the branch target cache
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module tb
  import btc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, fetch_req = 1'b0;
  logic prog_go = 1'b0, hreadyout, hresp, fetch_ack, fetch_stall, flash_rd_en;
  logic flash_wr_busy, flash_inval;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, fetch_data, flash_rd_data;
  logic [16:0] prog_addr = 17'h0, flash_inval_addr;
  logic [14:0] flash_rd_tag;
  btc_fetch_s fetch_info = '0;
  int n_errors = 0, num_checks = 0;
  // filter cases: tune, control, fetch flags, cycles of the repeated fetch
  logic [31:0] tbl [9] = '{32'h00660003, 32'h00e40403, 32'h00e60203, 32'h00ee0201,
    32'h00e20103, 32'h02e60003, 32'h01e60001, 32'h00a60003, 32'h04e60401};
  always #20 sys_clk = ~sys_clk;
  btc_branch_cache uut (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .fetch_req(fetch_req),
    .fetch_info(fetch_info), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
    .fetch_stall(fetch_stall), .flash_rd_en(flash_rd_en), .flash_rd_tag(flash_rd_tag),
    .flash_rd_data(flash_rd_data), .flash_wr_busy(flash_wr_busy), .flash_inval(flash_inval),
    .flash_inval_addr(flash_inval_addr), .flash_inval_page(1'b0));
  btc_flash_model flash (.sys_clk(sys_clk), .rst_b(rst_b), .flash_rd_en(flash_rd_en),
    .flash_rd_tag(flash_rd_tag), .prog_go(prog_go), .prog_addr(prog_addr),
    .flash_rd_data(flash_rd_data), .flash_wr_busy(flash_wr_busy),
    .flash_inval(flash_inval), .flash_inval_addr(flash_inval_addr));
  ////////////////////////////////////////////////////////////////////////////////
  // word the flash model hands out for an address
  function automatic logic [31:0] exp_word(input logic [16:0] a);
    return {1'b0, a[16:2], 1'b1, ~a[16:2]};
  endfunction
  // one single ahb-lite transfer, held until hready is sampled high
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int k;
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    k = 0;
    do begin @(posedge sys_clk); k++; end while (hreadyout !== 1'b1 && k < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    k = 0;
    do begin @(posedge sys_clk); k++; end while (hreadyout !== 1'b1 && k < 50);
    q = hrdata;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 8'h00, q);
    `CHK(q, {24'h000000, e})
  endtask
  // one core fetch; cyc 0 means any answer within three cycles
  task automatic fetch(input logic [16:0] a, input logic [2:0] fl, input int cyc);
    int k;
    logic st;
    @(posedge sys_clk);
    fetch_req <= 1'b1;
    fetch_info <= {a, fl};
    k = 0;
    st = 1'b0;
    do begin @(posedge sys_clk); #1; k++; st |= fetch_stall; end
      while (fetch_ack !== 1'b1 && k < 20);
    fetch_req <= 1'b0;
    `CHK(fetch_data, exp_word(a))
    `CHK(st, k > 1)
    if (cyc > 0) `CHK(k, cyc) else `CHK(k <= 3, 1'b1)
  endtask
  task automatic fetch2(input logic [16:0] a, input logic [2:0] fl, input int e2);
    fetch(a, fl, 3);
    // let the prefetch of the next word land, so the linear slot no
    // longer holds this word and only a real cache fill can give a hit
    repeat (4) @(posedge sys_clk);
    fetch(a, fl, e2);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    rchk(ADDR_CTRL, CTRL_RST);
    rchk(ADDR_TUNE, 8'h00);
    rchk(ADDR_FSTAT, 8'h00);
    rchk(ADDR_LOCK, 8'h3e);
    rchk(8'h90, 8'h00);
    fetch2(17'h00100, 3'b000, 1);
    fetch(17'h00104, 3'b000, 0);
    wreg(ADDR_CTRL, CTRL_RST | 8'h10);
    rchk(ADDR_CTRL, CTRL_RST);
    fetch2(17'h00100, 3'b000, 1);
    @(posedge sys_clk);
    prog_go <= 1'b1;
    prog_addr <= 17'h00102;
    @(posedge sys_clk);
    prog_go <= 1'b0;
    rchk(ADDR_FSTAT, 8'h01);
    repeat (10) @(posedge sys_clk);
    rchk(ADDR_FSTAT, 8'h00);
    fetch(17'h00100, 3'b000, 3);
    for (int i = 0; i < 9; i++) begin
      wreg(ADDR_TUNE, tbl[i][31:24]);
      wreg(ADDR_CTRL, tbl[i][23:16]);
      fetch2(17'h04000 + 17'(i * 16), tbl[i][10:8], int'(tbl[i][7:0]));
    end
    wreg(ADDR_CTRL, 8'hc6);
    fetch(17'h06000, 3'b000, 3);
    fetch(17'h06004, 3'b000, 3);
    wreg(ADDR_TUNE, 8'h00);
    wreg(ADDR_CTRL, CTRL_RST);
    wreg(ADDR_LOCK, 8'h80);
    fetch(17'h08000, 3'b100, 3);
    wreg(ADDR_LOCK, 8'h00);
    rchk(ADDR_LOCK, 8'h3d);
    fetch(17'h08000, 3'b000, 1);
    for (int t = 0; t < 2; t++) begin
      wreg(ADDR_TUNE, t[0] ? 8'h08 : 8'h00);
      for (int j = 0; j < 70; j++) begin
        fetch(17'h10000 + 17'(t * 4096) + 17'(j * 8), 3'b000, 3);
      end
      fetch(17'h08000, 3'b000, 1);
    end
    // pop undoes the one push, back to the reset pointer
    wreg(ADDR_LOCK, 8'h40);
    rchk(ADDR_LOCK, 8'h3e);
    fetch(17'h08000, 3'b000, 1);
    give_verdict();
  end
endmodule
`default_nettype wire
